//--- verilog/psp_params.svh
// Constants for the pipelined SRAM port: widths, burst and pipeline timing.
// Assumes inclusion by both ends and by the interface.
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH
`define PSP_ADDR_W      19
`define PSP_LANE_W      9
`define PSP_DATA_W      18
`define PSP_BURST_W     2
`define PSP_PIPE_DEPTH  2
`define PSP_SLEEP_CYC   2
`define PSP_CNT_ONE     2'h1
`define PSP_ZERO2       2'h0
`endif

//--- verilog/psp_pkg.sv
// Types shared by both ends of the pipelined SRAM port.
// Assumes psp_params.svh is on the include path.
`include "psp_params.svh"
package psp_pkg;
    typedef enum logic [1:0] {
        PSP_SLOT_IDLE  = 2'h0,
        PSP_SLOT_READ  = 2'h1,
        PSP_SLOT_WRITE = 2'h2
    } psp_slot_t;
    typedef enum logic [1:0] {
        PSP_PWR_AWAKE    = 2'h0,
        PSP_PWR_ENTERING = 2'h1,
        PSP_PWR_ASLEEP   = 2'h2
    } psp_pwr_t;
endpackage

//--- verilog/psp_if.sv
// Pin bundle between the controller and the SRAM port.
// Assumes the testbench resolves the shared data bus from both enables.
`timescale 1ns/100ps
`default_nettype none
`include "psp_params.svh"
interface psp_if;
    logic [`PSP_ADDR_W-1:0] addr;
    logic                   read_not_write;
    logic                   advance_or_load;
    logic                   chip_select_low_primary_n;
    logic                   chip_select_low_secondary_n;
    logic                   chip_select_high;
    logic                   clock_gate_n;
    logic                   lane_low_write_strobe_n;
    logic                   lane_high_write_strobe_n;
    logic                   output_enable_n;
    logic                   sleep_request;
    logic                   burst_interleaved;
    logic [`PSP_DATA_W-1:0] ctl_dq_out;
    logic                   ctl_dq_oe;
    logic [`PSP_DATA_W-1:0] mem_dq_out;
    logic                   mem_dq_oe;
    logic [`PSP_DATA_W-1:0] dq_in;
    modport ctl (
        output addr, read_not_write, advance_or_load, chip_select_low_primary_n,
               chip_select_low_secondary_n, chip_select_high, clock_gate_n,
               lane_low_write_strobe_n, lane_high_write_strobe_n, output_enable_n,
               sleep_request, burst_interleaved, ctl_dq_out, ctl_dq_oe,
        input  dq_in
    );
    modport mem (
        input  addr, read_not_write, advance_or_load, chip_select_low_primary_n,
               chip_select_low_secondary_n, chip_select_high, clock_gate_n,
               lane_low_write_strobe_n, lane_high_write_strobe_n, output_enable_n,
               sleep_request, burst_interleaved, dq_in,
        output mem_dq_out, mem_dq_oe
    );
endinterface
`default_nettype wire

//--- verilog/psp_mem.sv
// SRAM end of the pipelined port: 512K x 18, two-cycle data pipeline.
// Assumes the controller drives the psp_if pins synchronous to i_clk.
// How it works
// - read/write select latched on load, kept through burst
// - data on bus two edges after command
// - sample synchronous inputs on rising clock edge
// - load with any select inactive deselects
// - bus released two cycles after deselect
// - high select mirrors low selects; all needed
// - output enable asynchronously floats data pins
// - controller may hold output enable low
// - load while selected captures address and control
// - advance steps burst counter of running burst
// - advance ignores address and read/write select
// - burst order pin: high interleaved, low linear
// - sleep input enters standby; low for operation
// - data paths registered; two nine-bit lanes
// - clock gate high freezes all state but the sleep sequencer
// - per-lane write strobes, applied two cycles later
// - low address bits preset burst counter
// - counter wraps after fourth address
`timescale 1ns/100ps
`default_nettype none
`include "psp_params.svh"
module psp_mem
    import psp_pkg::*;
#(
    parameter int ADDR_W = `PSP_ADDR_W,
    parameter int WORDS  = 1 << `PSP_ADDR_W
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // Pins
    psp_if.mem        pins,
    // Status
    output logic      o_asleep,
    output logic      o_burst_active
);
    localparam int LW = `PSP_LANE_W;
    localparam int DW = `PSP_DATA_W;
    localparam int LANES = DW / LW;

    logic [DW-1:0]     mem [WORDS];
    logic [ADDR_W-1:0] base_addr;
    logic [1:0]        burst_start;
    logic [1:0]        burst_cnt;
    logic              burst_is_read;
    logic              burst_active;
    // Slot 0 was sampled last edge; slot 1 has its data on the bus now
    psp_slot_t         slot [`PSP_PIPE_DEPTH];
    logic [ADDR_W-1:0] slot_addr [`PSP_PIPE_DEPTH];
    logic [1:0]        slot_be [`PSP_PIPE_DEPTH];
    logic [DW-1:0]     rd_data;
    logic              rd_drive;
    psp_pwr_t          pwr;
    logic              enabled;
    logic              selected;
    logic              load;
    logic              adv;
    logic [1:0]        cur_low;
    logic [ADDR_W-1:0] cur_addr;
    logic              cur_valid;
    logic              cur_read;
    logic [1:0]        next_cnt;
    psp_slot_t         next_slot;
    logic              fwd_hit;
    logic [DW-1:0]     fwd_data;

    // Decode of the command pins sampled at this edge
    assign enabled  = !pins.clock_gate_n && pwr != PSP_PWR_ASLEEP;
    assign selected = !pins.chip_select_low_primary_n && !pins.chip_select_low_secondary_n
                      && pins.chip_select_high;
    assign load     = enabled && !pins.advance_or_load;
    assign adv      = enabled && pins.advance_or_load && burst_active;
    assign next_cnt = burst_cnt + `PSP_CNT_ONE;
    // Burst order applied to the running count
    assign cur_low  = pins.burst_interleaved ? (burst_start ^ next_cnt)
                                             : (burst_start + next_cnt);

    // Access entering the pipeline: a fresh load or the next burst step
    always_comb begin
        next_slot = PSP_SLOT_IDLE;
        cur_valid = 1'b0;
        cur_read  = 1'b0;
        cur_addr  = pins.addr;
        if (load && selected) begin
            cur_valid = 1'b1;
            cur_read  = pins.read_not_write;
        end else if (adv) begin
            cur_valid = 1'b1;
            cur_read  = burst_is_read;
            cur_addr  = {base_addr[ADDR_W-1:2], cur_low};
        end
        if (cur_valid)
            next_slot = cur_read ? PSP_SLOT_READ : PSP_SLOT_WRITE;
    end

    // Burst tracking
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            base_addr     <= '0;
            burst_start   <= `PSP_ZERO2;
            burst_cnt     <= `PSP_ZERO2;
            burst_is_read <= 1'b0;
            burst_active  <= 1'b0;
        end else if (load) begin
            burst_active <= selected;
            if (selected) begin
                base_addr     <= pins.addr;
                burst_start   <= pins.addr[1:0];
                burst_cnt     <= `PSP_ZERO2;
                burst_is_read <= pins.read_not_write;
            end
        end else if (adv) begin
            burst_cnt <= next_cnt;
        end
    end

    // Two-stage access pipeline
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < `PSP_PIPE_DEPTH; i++) begin
                slot[i]      <= PSP_SLOT_IDLE;
                slot_addr[i] <= '0;
                slot_be[i]   <= `PSP_ZERO2;
            end
        end else if (enabled) begin
            slot[0]      <= next_slot;
            slot_addr[0] <= cur_addr;
            slot_be[0]   <= {!pins.lane_high_write_strobe_n, !pins.lane_low_write_strobe_n};
            slot[1]      <= slot[0];
            slot_addr[1] <= slot_addr[0];
            slot_be[1]   <= slot_be[0];
        end else if (pwr == PSP_PWR_ASLEEP) begin
            slot[0]      <= PSP_SLOT_IDLE;
            slot[1]      <= PSP_SLOT_IDLE;
        end
    end

    // Write path: registered data lanes, committed two edges after command
    always_ff @(posedge i_clk) begin
        if (enabled && slot[1] == PSP_SLOT_WRITE) begin
            if (slot_be[1][0])
                mem[slot_addr[1]][LW-1:0] <= pins.dq_in[LW-1:0];
            if (slot_be[1][1])
                mem[slot_addr[1]][DW-1:LW] <= pins.dq_in[DW-1:LW];
        end
    end

    // A write committing on the edge that loads a read of the same word is
    // forwarded lane by lane, so a read right behind a write sees the new data
    assign fwd_hit = slot[0] == PSP_SLOT_READ && slot[1] == PSP_SLOT_WRITE
                     && slot_addr[0] == slot_addr[1];
    always_comb begin
        fwd_data = mem[slot_addr[0]];
        for (int g = 0; g < LANES; g++) begin
            if (fwd_hit && slot_be[1][g])
                fwd_data[g*LW +: LW] = pins.dq_in[g*LW +: LW];
        end
    end

    // Read path: output register loaded on every enabled edge, driven for read slots only
    // Data launches one edge after slot 0 fills, so it stands in the second cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_data  <= '0;
            rd_drive <= 1'b0;
        end else if (enabled) begin
            rd_drive <= slot[0] == PSP_SLOT_READ;
            rd_data  <= fwd_data;
        end else if (pwr == PSP_PWR_ASLEEP) begin
            rd_drive <= 1'b0;
        end
    end

    // Sleep sequencing: two cycles to enter
    // Standby drops pending accesses; the array keeps its contents
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwr <= PSP_PWR_AWAKE;
        end else begin
            case (pwr)
                PSP_PWR_AWAKE:    pwr <= pins.sleep_request ? PSP_PWR_ENTERING : PSP_PWR_AWAKE;
                PSP_PWR_ENTERING: pwr <= pins.sleep_request ? PSP_PWR_ASLEEP : PSP_PWR_AWAKE;
                PSP_PWR_ASLEEP:   pwr <= pins.sleep_request ? PSP_PWR_ASLEEP : PSP_PWR_AWAKE;
                default:          pwr <= PSP_PWR_AWAKE;
            endcase
        end
    end

    // Status outputs
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_asleep       <= 1'b0;
            o_burst_active <= 1'b0;
        end else begin
            o_asleep       <= pwr == PSP_PWR_ASLEEP;
            o_burst_active <= burst_active;
        end
    end

    // Output enable gates the pins without the clock
    assign pins.mem_dq_out = rd_data;
    assign pins.mem_dq_oe  = rd_drive && !pins.output_enable_n;
endmodule
`default_nettype wire

//--- verilog/psp_ctl.sv
// Controller end of the pipelined SRAM port.
// Assumes one request per cycle from the user side, synchronous to i_clk.
`timescale 1ns/100ps
`default_nettype none
`include "psp_params.svh"
module psp_ctl
    import psp_pkg::*;
#(
    parameter int ADDR_W = `PSP_ADDR_W
) (
    // Clock, reset, clock enable
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_clk_en,
    // User request
    input  wire logic              i_req,
    input  wire logic              i_burst,
    input  wire logic              i_read,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [1:0]        i_lane_en,
    input  wire logic [`PSP_DATA_W-1:0] i_wdata,
    input  wire logic              i_sleep,
    input  wire logic              i_interleaved,
    // User answer
    output logic                   o_rvalid,
    output logic [`PSP_DATA_W-1:0] o_rdata,
    // Pins
    psp_if.ctl                     pins
);
    psp_slot_t         slot [`PSP_PIPE_DEPTH];
    logic [`PSP_DATA_W-1:0] wdata [`PSP_PIPE_DEPTH];
    logic              burst_read;
    logic              burst_open;
    logic [`PSP_DATA_W-1:0] cmd_wdata;

    // Command pins registered; advance only continues an open burst
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pins.addr                        <= '0;
            pins.read_not_write              <= 1'b1;
            pins.advance_or_load             <= 1'b0;
            pins.chip_select_low_primary_n   <= 1'b1;
            pins.chip_select_low_secondary_n <= 1'b1;
            pins.chip_select_high            <= 1'b0;
            pins.lane_low_write_strobe_n     <= 1'b1;
            pins.lane_high_write_strobe_n    <= 1'b1;
            burst_read                       <= 1'b1;
            cmd_wdata                        <= '0;
        end else if (i_clk_en) begin
            pins.advance_or_load             <= i_req && i_burst;
            pins.chip_select_low_primary_n   <= !i_req;
            pins.chip_select_low_secondary_n <= !i_req;
            pins.chip_select_high            <= i_req;
            pins.addr                        <= i_addr;
            pins.read_not_write              <= i_read;
            cmd_wdata                        <= i_wdata;
            pins.lane_low_write_strobe_n     <= !(i_lane_en[0] && !(i_burst ? burst_read : i_read));
            pins.lane_high_write_strobe_n    <= !(i_lane_en[1] && !(i_burst ? burst_read : i_read));
            if (i_req && !i_burst)
                burst_read <= i_read;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pins.clock_gate_n      <= 1'b1;
            pins.output_enable_n   <= 1'b1;
            pins.sleep_request     <= 1'b0;
            pins.burst_interleaved <= 1'b1;
        end else begin
            pins.clock_gate_n      <= !i_clk_en;
            pins.output_enable_n   <= 1'b0;
            pins.sleep_request     <= i_sleep;
            pins.burst_interleaved <= i_interleaved;
        end
    end

    // Track each command two cycles ahead of its data
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < `PSP_PIPE_DEPTH; i++) begin
                slot[i]  <= PSP_SLOT_IDLE;
                wdata[i] <= '0;
            end
            pins.ctl_dq_out <= '0;
            pins.ctl_dq_oe  <= 1'b0;
            o_rvalid        <= 1'b0;
            o_rdata         <= '0;
            burst_open      <= 1'b0;
        end else if (!pins.clock_gate_n) begin
            // An advance with no open burst is a no-op on the far side
            if (!pins.advance_or_load)
                burst_open <= pins.chip_select_high;
            slot[0]  <= (pins.advance_or_load ? !burst_open : !pins.chip_select_high) ? PSP_SLOT_IDLE
                      : (pins.advance_or_load ? burst_read : pins.read_not_write) ? PSP_SLOT_READ
                      : PSP_SLOT_WRITE;
            wdata[0] <= cmd_wdata;
            slot[1]  <= slot[0];
            wdata[1] <= wdata[0];
            pins.ctl_dq_oe  <= slot[0] == PSP_SLOT_WRITE;
            pins.ctl_dq_out <= wdata[0];
            o_rvalid        <= slot[1] == PSP_SLOT_READ;
            o_rdata         <= pins.dq_in;
        end else begin
            o_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verif/psp_sva.sv
// Checker for the SRAM port pins: pipeline timing and data bus ownership.
// Assumes instantiation beside psp_if with its signals as plain inputs.
`timescale 1ns/100ps
`default_nettype none
module psp_sva (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic read_not_write,
    input wire logic advance_or_load,
    input wire logic chip_select_low_primary_n,
    input wire logic chip_select_low_secondary_n,
    input wire logic chip_select_high,
    input wire logic clock_gate_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic ctl_dq_oe,
    input wire logic mem_dq_oe
);
    logic sel;
    logic ld;
    logic adv;
    assign sel = !chip_select_low_primary_n && !chip_select_low_secondary_n && chip_select_high;
    assign ld  = !advance_or_load && !clock_gate_n && !sleep_request;
    assign adv = advance_or_load && !clock_gate_n && !sleep_request;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    AST_OE_FLOAT: assert property (output_enable_n |-> !mem_dq_oe)
        else $error("data bus driven while output enable high");
    AST_NO_CONFLICT: assert property (!(ctl_dq_oe && mem_dq_oe))
        else $error("both ends drive the data bus");
    AST_READ_DATA: assert property (ld && sel && read_not_write ##1 !clock_gate_n
        |-> ##1 (mem_dq_oe || output_enable_n)) else $error("read data missing two cycles after load");
    AST_WRITE_DATA: assert property (ld && sel && !read_not_write ##1 !clock_gate_n
        |-> ##1 (ctl_dq_oe && !mem_dq_oe)) else $error("write slot bus ownership wrong");
    AST_DESELECT: assert property (ld && !sel ##1 !clock_gate_n |-> ##1 !mem_dq_oe)
        else $error("bus driven after deselect");
    AST_DESELECT_NOP: assert property (ld && !sel ##1 adv ##1 !clock_gate_n |-> ##1 !mem_dq_oe)
        else $error("bus driven in advance after deselect");
    AST_BURST_READ: assert property (ld && sel && read_not_write ##1 adv ##1 !clock_gate_n
        |-> ##1 (mem_dq_oe || output_enable_n)) else $error("burst read data missing");
    AST_BURST_WRITE: assert property (ld && sel && !read_not_write ##1 adv ##1 !clock_gate_n
        |-> ##1 (ctl_dq_oe && !mem_dq_oe)) else $error("burst write slot bus ownership wrong");
    AST_FREEZE: assert property (clock_gate_n ##1 $stable(output_enable_n) |-> $stable(mem_dq_oe))
        else $error("data drive changed on a gated edge");
endmodule
`default_nettype wire

//--- verif/pipelined_sram_port_control_bench.sv
// Self-checking bench: controller and SRAM end joined by psp_if.
// Assumes the design files and psp_params.svh are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pipelined_sram_port_control_bench;
    logic        i_clk, i_rst_b, clk_en, req, burst, rd, sleep, inter, asleep, rvalid, r, brd, bact, bopen;
    logic [18:0] addr, bst, base;
    logic [1:0]  lane, bcnt;
    logic [17:0] wdata, rdata;
    logic [17:0] model [int];
    logic [17:0] expq [$];
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;
    psp_if pins ();
    // Resolved data bus seen by both ends
    assign pins.dq_in = pins.mem_dq_oe ? pins.mem_dq_out : (pins.ctl_dq_oe ? pins.ctl_dq_out : 'z);
    psp_ctl u_psp_ctl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_clk_en(clk_en), .i_req(req), .i_burst(burst),
        .i_read(rd), .i_addr(addr), .i_lane_en(lane), .i_wdata(wdata), .i_sleep(sleep),
        .i_interleaved(inter), .o_rvalid(rvalid), .o_rdata(rdata), .pins(pins.ctl));
    psp_mem u_psp_mem (.i_clk(i_clk), .i_rst_b(i_rst_b), .pins(pins.mem), .o_asleep(asleep),
        .o_burst_active(bact));
    psp_sva u_psp_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .read_not_write(pins.read_not_write),
        .advance_or_load(pins.advance_or_load), .chip_select_low_primary_n(pins.chip_select_low_primary_n),
        .chip_select_low_secondary_n(pins.chip_select_low_secondary_n), .chip_select_high(pins.chip_select_high),
        .clock_gate_n(pins.clock_gate_n), .output_enable_n(pins.output_enable_n),
        .sleep_request(pins.sleep_request), .ctl_dq_oe(pins.ctl_dq_oe), .mem_dq_oe(pins.mem_dq_oe));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One request per cycle; the model tracks the burst address
    task automatic op(input logic b, input logic w, input logic [18:0] a, input logic [1:0] le);
        logic [18:0] ea;
        logic [17:0] d;
        d = 18'($urandom);
        if (!b) begin
            bst = a;
            bcnt = 2'h0;
            brd = w;
            bopen = 1'b1;
        end else begin
            bcnt = bcnt + 2'h1;
        end
        ea = {bst[18:2], inter ? bst[1:0] ^ bcnt : bst[1:0] + bcnt};
        // An advance after a deselect is ignored by both ends
        if (bopen && brd) begin
            expq.push_back(model[ea]);
        end else if (bopen) begin
            if (le[0]) model[ea][8:0] = d[8:0];
            if (le[1]) model[ea][17:9] = d[17:9];
        end
        {req, burst, rd, addr, lane, wdata} = {1'b1, b, b ? 1'($urandom) : w, a, le, d};
        @(negedge i_clk);
    endtask
    task automatic idle(input int n);
        req = 1'b0;
        bopen = bopen && !clk_en;
        repeat (n) @(negedge i_clk);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(negedge i_clk) begin
        if (rvalid === 1'b1) begin
            chk(rdata, expq.pop_front());
        end
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        {clk_en, req, burst, rd, addr, lane, wdata, sleep, inter, bopen} = '0;
        i_rst_b = 1'b0;
        void'($urandom(88));
        base = 19'($urandom) & 19'h7fff8;
        repeat (8) @(negedge i_clk);
        i_rst_b = 1'b1;
        clk_en = 1'b1;
        for (int k = 0; k < 8; k++) op(0, 0, base + 19'(k), 2'h3);
        op(0, 0, 19'h7ffff, 2'h3);
        for (int k = 0; k < 4; k++) op(0, 1, base + 19'(k), 2'h3);
        op(0, 1, 19'h7ffff, 2'h3);
        op(0, 0, base, 2'h1);
        op(0, 0, base + 19'h1, 2'h2);
        idle(3);
        op(0, 1, base, 2'h3);
        op(0, 1, base + 19'h1, 2'h3);
        for (int m = 0; m < 2; m++) begin
            idle(4);
            inter = m[0];
            for (int s = 0; s < 4; s++) begin
                op(0, 1, base + 19'(s), 2'h3);
                repeat (5) op(1, 0, 19'($urandom), 2'h3);
            end
        end
        op(0, 0, base + 19'h6, 2'h3);
        repeat (3) op(1, 1, 19'($urandom), 2'h3);
        op(0, 1, base + 19'h5, 2'h3);
        clk_en = 1'b0;
        idle(3);
        clk_en = 1'b1;
        for (int k = 0; k < 16; k++) begin
            r = 1'($urandom);
            op(0, r, base + 19'({r, 2'($urandom)}), 2'h3);
        end
        idle(4);
        sleep = 1'b1;
        idle(4);
        chk({17'h0, asleep}, 18'h1);
        sleep = 1'b0;
        idle(4);
        chk({17'h0, asleep}, 18'h0);
        idle(1);
        op(1, 1, 19'($urandom), 2'h3);
        for (int k = 0; k < 4; k++) op(0, 1, base + 19'(k), 2'h3);
        idle(2);
        chk({17'h0, bact}, 18'h1);
        idle(8);
        chk({17'h0, bact}, 18'h0);
        chk(18'(expq.size()), 18'h0);
        finish_test();
    end
endmodule
`default_nettype wire
